/* File: rtl/crb_pkg.sv */
// constants and types for the coprocessor reset and bus sizing link
package crb_pkg;
    localparam int CLK_PERIOD_NS    = 8;
    localparam int PWRUP_MIN_CLKS   = 4;
    localparam int RERST_MIN_CLKS   = 3;
    localparam int COMPAT_MIN_CLKS  = 10;
    localparam int PWRUP_COMPAT_MS  = 100;
    localparam int PWRUP_COMPAT_CLKS =
        (PWRUP_COMPAT_MS * 1000000) / CLK_PERIOD_NS;
    localparam int NUM_FP_REGS      = 8;
    localparam int FP_WIDTH         = 80;
    localparam int CSR_WIDTH        = 32;
    localparam int DATA_WIDTH       = 32;
    localparam int WAIT_CYCLES      = 2;
    localparam int BYTE_LANE_W      = 8;
    localparam int HALF_LANE_W      = 16;
    localparam logic [FP_WIDTH-1:0] QNAN_VALUE = 80'h7fff_ffff_ffff_ffff_ffff;
    localparam logic [CSR_WIDTH-1:0] CSR_RESET = 32'h0000_0000;
    localparam logic [2:0] REG_FPCR  = 3'h0;
    localparam logic [2:0] REG_FPSR  = 3'h1;
    localparam logic [2:0] REG_FPIAR = 3'h2;

    typedef enum logic [1:0] {
        CRB_W8  = 2'b00,
        CRB_W16 = 2'b01,
        CRB_W32 = 2'b10
    } crb_width_e;

    // strap decode used by the coprocessor end; the host drives the straps directly
    function automatic crb_width_e crb_decode_width(
        input logic size_strap,
        input logic addr_strap
    );
        if (!size_strap)
            return CRB_W8;
        else if (addr_strap)
            return CRB_W32;
        else
            return CRB_W16;
    endfunction
endpackage

/* File: rtl/crb_if.sv */
// link between host and coprocessor reset/bus-sizing port
`timescale 1ns/1ps
interface crb_if;
    import crb_pkg::*;
    logic                  reset_n;
    logic                  low_address_strap;
    logic                  size_strap;
    logic                  address_strobe_n;
    logic                  rw;
    logic                  register_select_bit4;
    logic [2:0]            reg_sel;
    logic [DATA_WIDTH-1:0] wdata;
    logic [DATA_WIDTH-1:0] rdata;
    logic                  byte_port_ack_n;
    logic                  word_port_ack_n;
    logic                  ack_oe;

    modport dev (
        input  reset_n, low_address_strap, size_strap, address_strobe_n,
        input  rw, register_select_bit4, reg_sel, wdata,
        output rdata, byte_port_ack_n, word_port_ack_n, ack_oe
    );
    modport host (
        output reset_n, low_address_strap, size_strap, address_strobe_n,
        output rw, register_select_bit4, reg_sel, wdata,
        input  rdata, byte_port_ack_n, word_port_ack_n, ack_oe
    );
endinterface

/* File: rtl/crb_ack_gen.sv */
// acknowledge pattern generator from bus width and select bit
`timescale 1ns/1ps
module crb_ack_gen
    import crb_pkg::*;
(
    // control
    input  wire crb_width_e i_width,
    input  wire logic       i_sel_bit4,
    input  wire logic       i_done,
    // acks, active low
    output logic            o_byte_ack_n,
    output logic            o_word_ack_n
);
    always_comb begin
        o_byte_ack_n = 1'b1;
        o_word_ack_n = 1'b1;
        if (i_done) begin
            case (i_width)
                CRB_W32: begin
                    o_word_ack_n = 1'b0;
                    o_byte_ack_n = !i_sel_bit4;
                end
                CRB_W16: begin
                    o_word_ack_n = 1'b0;
                end
                CRB_W8: begin
                    o_byte_ack_n = 1'b0;
                end
                default: begin
                    o_word_ack_n = 1'b1;
                end
            endcase
        end
    end
endmodule

/* File: rtl/crb_device.sv */
// coprocessor end: reset state, strap capture, bus acknowledge
`timescale 1ns/1ps
module crb_device
    import crb_pkg::*;
#(
    parameter int WAIT_N = WAIT_CYCLES
)
(
    // clock
    input  wire logic                 i_core_clk,
    // link
    crb_if.dev                        bus,
    // user side
    output logic [1:0]                o_width,
    output logic                      o_in_reset,
    output logic [FP_WIDTH-1:0]       o_fp0,
    output logic [CSR_WIDTH-1:0]      o_fpcr,
    output logic [CSR_WIDTH-1:0]      o_fpsr,
    output logic [CSR_WIDTH-1:0]      o_fpiar
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_ACK  = 2'b10
    } crb_dst_e;

    logic [FP_WIDTH-1:0]  fp_reg   [NUM_FP_REGS];
    logic [FP_WIDTH-1:0]  fp_next  [NUM_FP_REGS];
    logic [CSR_WIDTH-1:0] fpcr_reg, fpcr_next;
    logic [CSR_WIDTH-1:0] fpsr_reg, fpsr_next;
    logic [CSR_WIDTH-1:0] fpiar_reg, fpiar_next;
    crb_width_e           width_reg, width_next;
    logic                 cap_reg, cap_next;
    crb_dst_e             st_reg, st_next;
    logic [7:0]           cnt_reg, cnt_next;
    logic [DATA_WIDTH-1:0] rd_reg, rd_next;
    logic                 bit4_reg, bit4_next;
    logic                 rst_reg, rst_next;
    logic                 done;

    always_comb begin
        fp_next    = fp_reg;
        fpcr_next  = fpcr_reg;
        fpsr_next  = fpsr_reg;
        fpiar_next = fpiar_reg;
        width_next = width_reg;
        cap_next   = cap_reg;
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        rd_next    = rd_reg;
        bit4_next  = bit4_reg;
        rst_next   = 1'b0;
        if (!bus.reset_n) begin
            for (int i = 0; i < NUM_FP_REGS; i++)
                fp_next[i] = QNAN_VALUE;
            fpcr_next  = CSR_RESET;
            fpsr_next  = CSR_RESET;
            fpiar_next = CSR_RESET;
            cap_next   = 1'b0;
            st_next    = ST_IDLE;
            cnt_next   = 8'h00;
            rd_next    = '0;
            rst_next   = 1'b1;
        end else begin
            if (!cap_reg) begin
                width_next = crb_decode_width(bus.size_strap,
                                              bus.low_address_strap);
                cap_next   = 1'b1;
            end
            case (st_reg)
                ST_IDLE: begin
                    if (!bus.address_strobe_n && cap_reg) begin
                        bit4_next = bus.register_select_bit4;
                        cnt_next  = 8'h00;
                        st_next   = ST_WAIT;
                        if (bus.rw) begin
                            case (bus.reg_sel)
                                REG_FPCR:  rd_next = fpcr_reg;
                                REG_FPSR:  rd_next = fpsr_reg;
                                REG_FPIAR: rd_next = fpiar_reg;
                                default:   rd_next = '0;
                            endcase
                        end else begin
                            case (bus.reg_sel)
                                REG_FPCR:  fpcr_next  = bus.wdata;
                                REG_FPSR:  fpsr_next  = bus.wdata;
                                REG_FPIAR: fpiar_next = bus.wdata;
                                default:   fpcr_next  = fpcr_reg;
                            endcase
                        end
                    end
                end
                ST_WAIT: begin
                    // hold acks off during wait count
                    if (cnt_reg >= 8'(WAIT_N - 1))
                        st_next = ST_ACK;
                    else
                        cnt_next = cnt_reg + 8'h01;
                    if (bus.address_strobe_n)
                        st_next = ST_IDLE;
                end
                ST_ACK: begin
                    // strobe release ends the cycle
                    if (bus.address_strobe_n)
                        st_next = ST_IDLE;
                end
                default: st_next = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        fp_reg    <= fp_next;
        fpcr_reg  <= fpcr_next;
        fpsr_reg  <= fpsr_next;
        fpiar_reg <= fpiar_next;
        width_reg <= width_next;
        cap_reg   <= cap_next;
        st_reg    <= st_next;
        cnt_reg   <= cnt_next;
        rd_reg    <= rd_next;
        bit4_reg  <= bit4_next;
        rst_reg   <= rst_next;
    end

    // acks stay off while strobe is already released
    assign done = (st_reg == ST_ACK) && !bus.address_strobe_n;

    crb_ack_gen i_crb_ack_gen (
        .i_width      (width_reg),
        .i_sel_bit4   (bit4_reg),
        .i_done       (done),
        .o_byte_ack_n (bus.byte_port_ack_n),
        .o_word_ack_n (bus.word_port_ack_n)
    );

    // drive acks only inside a selected cycle
    assign bus.ack_oe = (st_reg != ST_IDLE);
    assign bus.rdata  = rd_reg;
    assign o_width    = width_reg;
    assign o_in_reset = rst_reg;
    assign o_fp0      = fp_reg[0];
    assign o_fpcr     = fpcr_reg;
    assign o_fpsr     = fpsr_reg;
    assign o_fpiar    = fpiar_reg;
endmodule

/* File: rtl/crb_host.sv */
// host end: reset pulse generation, straps and bus cycles
`timescale 1ns/1ps
module crb_host
    import crb_pkg::*;
#(
    parameter int PWRUP_CLKS = PWRUP_COMPAT_CLKS,
    parameter int RERST_CLKS = COMPAT_MIN_CLKS
)
(
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_n,
    // configuration
    input  wire logic [1:0]            i_width_sel,
    input  wire logic                  i_soft_reset,
    // request
    input  wire logic                  i_req,
    input  wire logic                  i_rw,
    input  wire logic [2:0]            i_reg_sel,
    input  wire logic                  i_sel_bit4,
    input  wire logic [DATA_WIDTH-1:0] i_wdata,
    // answer
    output logic                       o_busy,
    output logic                       o_done,
    output logic [DATA_WIDTH-1:0]      o_rdata,
    output logic                       o_host_transfer_ack,
    // link
    crb_if.host                        bus
);
    typedef enum logic [1:0] {
        HS_RESET = 2'b00,
        HS_IDLE  = 2'b01,
        HS_CYCLE = 2'b10,
        HS_END   = 2'b11
    } crb_hst_e;

    crb_hst_e              st_reg, st_next;
    logic [31:0]           cnt_reg, cnt_next;
    logic                  rw_reg, rw_next;
    logic [2:0]            sel_reg, sel_next;
    logic                  b4_reg, b4_next;
    logic [DATA_WIDTH-1:0] wd_reg, wd_next;
    logic [DATA_WIDTH-1:0] rd_reg, rd_next;
    logic                  done_reg, done_next;
    logic                  ack;

    // word ack serves as transfer ack outside 8-bit
    assign ack = (i_width_sel == 2'(CRB_W8)) ? !bus.byte_port_ack_n
                                             : !bus.word_port_ack_n;

    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        rw_next   = rw_reg;
        sel_next  = sel_reg;
        b4_next   = b4_reg;
        wd_next   = wd_reg;
        rd_next   = rd_reg;
        done_next = 1'b0;
        case (st_reg)
            HS_RESET: begin
                // hold reset long enough
                // counts down so a later pulse may outlast power-up
                if (cnt_reg == 32'h0)
                    st_next = HS_IDLE;
                else
                    cnt_next = cnt_reg - 32'h1;
            end
            HS_IDLE: begin
                if (i_soft_reset) begin
                    cnt_next = 32'(RERST_CLKS - 1);
                    st_next  = HS_RESET;
                end else if (i_req) begin
                    rw_next  = i_rw;
                    sel_next = i_reg_sel;
                    b4_next  = i_sel_bit4;
                    if (i_width_sel == 2'(CRB_W8))
                        wd_next = {(DATA_WIDTH / BYTE_LANE_W)
                                   {i_wdata[BYTE_LANE_W-1:0]}};
                    else if (i_width_sel == 2'(CRB_W32))
                        wd_next = i_wdata;
                    else
                        wd_next = {(DATA_WIDTH / HALF_LANE_W)
                                   {i_wdata[HALF_LANE_W-1:0]}};
                    st_next  = HS_CYCLE;
                end
            end
            HS_CYCLE: begin
                if (ack) begin
                    rd_next   = bus.rdata;
                    done_next = 1'b1;
                    st_next   = HS_END;
                end
            end
            HS_END: st_next = HS_IDLE;
            default: st_next = HS_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_reg   <= HS_RESET;
            cnt_reg  <= 32'(PWRUP_CLKS - 1);
            rw_reg   <= 1'b1;
            sel_reg  <= 3'h0;
            b4_reg   <= 1'b0;
            wd_reg   <= '0;
            rd_reg   <= '0;
            done_reg <= 1'b0;
        end else begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            rw_reg   <= rw_next;
            sel_reg  <= sel_next;
            b4_reg   <= b4_next;
            wd_reg   <= wd_next;
            rd_reg   <= rd_next;
            done_reg <= done_next;
        end
    end

    assign bus.reset_n = (st_reg != HS_RESET);
    assign bus.size_strap        = (i_width_sel != 2'(CRB_W8));
    assign bus.low_address_strap = (i_width_sel == 2'(CRB_W32));
    assign bus.address_strobe_n  = (st_reg != HS_CYCLE);
    assign bus.rw                   = rw_reg;
    assign bus.reg_sel              = sel_reg;
    assign bus.register_select_bit4 = b4_reg;
    assign bus.wdata                = wd_reg;
    assign o_busy              = (st_reg != HS_IDLE);
    assign o_done              = done_reg;
    assign o_rdata             = rd_reg;
    assign o_host_transfer_ack = ack;
endmodule

/* File: verif/crb_link_monitor.sv */
// concurrent checks on the host/coprocessor link
`timescale 1ns/1ps
module crb_link_monitor (
    input wire logic       i_core_clk,
    input wire logic       reset_n,
    input wire logic       low_address_strap,
    input wire logic       size_strap,
    input wire logic       address_strobe_n,
    input wire logic       rw,
    input wire logic       register_select_bit4,
    input wire logic [2:0] reg_sel,
    input wire logic       byte_port_ack_n,
    input wire logic       word_port_ack_n
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!reset_n);
    logic w32;
    logic idle;
    assign w32  = size_strap && low_address_strap;
    assign idle = byte_port_ack_n && word_port_ack_n;

    chk_w16_byte_quiet: assert property (
        size_strap && !low_address_strap |-> byte_port_ack_n)
        else $error("byte ack in 16-bit mode");
    chk_w8_word_quiet: assert property (
        !size_strap |-> word_port_ack_n)
        else $error("word ack in 8-bit mode");
    chk_w32_ack_pair: assert property (
        w32 && !address_strobe_n && !word_port_ack_n
        |-> byte_port_ack_n == !register_select_bit4)
        else $error("32-bit ack pair wrong");
    chk_ack_wait_states: assert property (
        $fell(address_strobe_n) |-> idle [*2] ##[1:4] !idle)
        else $error("ack too early or never");
    chk_ack_in_cycle: assert property (
        !idle |-> !address_strobe_n || $past(!address_strobe_n))
        else $error("ack outside a bus cycle");
    chk_ack_release: assert property (
        $rose(address_strobe_n) |-> ##[0:2] idle)
        else $error("ack not released");
    chk_strobe_held: assert property (
        !address_strobe_n && idle |=> !address_strobe_n)
        else $error("strobe dropped before ack");
    chk_qual_stable: assert property (
        !address_strobe_n && $past(!address_strobe_n)
        |-> $stable(rw) && $stable(reg_sel) && $stable(register_select_bit4))
        else $error("qualifiers moved under strobe");
    chk_straps_static: assert property (
        $stable(size_strap) && $stable(low_address_strap))
        else $error("strap changed out of reset");
    // the reset line itself must not be masked by reset
    chk_reset_pulse: assert property (disable iff (1'b0)
        $fell(reset_n) |-> !reset_n [*3])
        else $error("reset pulse too short");

    cover property (w32 && !byte_port_ack_n && !word_port_ack_n);
    cover property (size_strap && !low_address_strap && !word_port_ack_n);
    cover property (!size_strap && !byte_port_ack_n);
    cover property ($rose(reset_n));
endmodule

/* File: verif/coprocessor_reset_and_bus_sizing_bench.sv */
// self-checking bench: host and coprocessor ends joined by the link
`timescale 1ns/1ps
module coprocessor_reset_and_bus_sizing_bench;
    import crb_pkg::*;
    localparam int PW = 4;
    localparam int RW = 10;
    logic                  i_core_clk   = 1'b0;
    logic                  i_rst_n      = 1'b0;
    logic [1:0]            i_width_sel  = 2'h2;
    logic                  i_soft_reset = 1'b0;
    logic                  i_req        = 1'b0;
    logic                  i_rw         = 1'b0;
    logic [2:0]            i_reg_sel    = 3'h0;
    logic                  i_sel_bit4   = 1'b0;
    logic [DATA_WIDTH-1:0] i_wdata      = 32'h0;
    logic                  busy;
    logic                  done;
    logic                  hack;
    logic [DATA_WIDTH-1:0] rdata;
    logic [1:0]            dev_width;
    logic                  in_reset;
    logic [FP_WIDTH-1:0]   fp0;
    logic [CSR_WIDTH-1:0]  fpcr;
    logic [CSR_WIDTH-1:0]  fpsr;
    logic [CSR_WIDTH-1:0]  fpiar;
    int                    err_count = 0;
    int                    samples_checked = 0;

    always #4 i_core_clk = ~i_core_clk;

    crb_if link ();
    crb_host #(.PWRUP_CLKS(PW), .RERST_CLKS(RW)) i_crb_host (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_width_sel(i_width_sel), .i_soft_reset(i_soft_reset),
        .i_req(i_req), .i_rw(i_rw), .i_reg_sel(i_reg_sel),
        .i_sel_bit4(i_sel_bit4), .i_wdata(i_wdata), .o_busy(busy),
        .o_done(done), .o_rdata(rdata), .o_host_transfer_ack(hack),
        .bus(link));
    crb_device i_crb_device (
        .i_core_clk(i_core_clk), .bus(link), .o_width(dev_width),
        .o_in_reset(in_reset), .o_fp0(fp0), .o_fpcr(fpcr),
        .o_fpsr(fpsr), .o_fpiar(fpiar));
    crb_link_monitor i_crb_link_monitor (
        .i_core_clk(i_core_clk), .reset_n(link.reset_n),
        .low_address_strap(link.low_address_strap),
        .size_strap(link.size_strap),
        .address_strobe_n(link.address_strobe_n), .rw(link.rw),
        .register_select_bit4(link.register_select_bit4),
        .reg_sel(link.reg_sel), .byte_port_ack_n(link.byte_port_ack_n),
        .word_port_ack_n(link.word_port_ack_n));

    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // bounded count of low cycles on the link reset
    task automatic low_count(output int n);
        n = 0;
        for (int k = 0; k < 60 && !(n > 0 && link.reset_n); k++) begin
            @(posedge i_core_clk);
            if (!link.reset_n) n++;
        end
    endtask

    task automatic check_init();
        check(fp0, QNAN_VALUE);
        check({fpcr, fpsr, fpiar}, '0);
    endtask

    // width only changes under reset, straps stay static after
    task automatic do_reset(input crb_width_e w);
        int n;
        @(posedge i_core_clk);
        i_rst_n     <= 1'b0;
        // straps move only once the link reset is already low
        repeat (2) @(posedge i_core_clk);
        i_width_sel <= w;
        repeat (8) @(posedge i_core_clk);
        check(in_reset, 1'b1);
        i_rst_n <= 1'b1;
        low_count(n);
        check(n >= PW && n <= PW + 3, 1'b1);
        repeat (2) @(posedge i_core_clk);
        check(in_reset, 1'b0);
        check(busy, 1'b0);
    endtask

    // seen collects {host ack, word ack, byte ack} over the cycle
    task automatic access(input logic r, input logic b4,
                          input logic [31:0] d, output logic [2:0] seen);
        seen = 3'h0;
        @(posedge i_core_clk);
        i_req      <= 1'b1;
        i_rw       <= r;
        i_sel_bit4 <= b4;
        i_wdata    <= d;
        i_reg_sel  <= REG_FPCR;
        @(posedge i_core_clk);
        i_req <= 1'b0;
        for (int k = 0; k < 20 && done !== 1'b1; k++) begin
            @(posedge i_core_clk);
            seen |= {hack, !link.word_port_ack_n, !link.byte_port_ack_n};
        end
        check(done, 1'b1);
    endtask

    task automatic t_width(input crb_width_e w);
        logic [2:0] s;
        logic [31:0] d;
        logic [31:0] want;
        do_reset(w);
        check_init();
        check(dev_width, w);
        check(link.size_strap, w != CRB_W8);
        if (w != CRB_W8)
            check(link.low_address_strap, w == CRB_W32);
        for (int b = 0; b < 2; b++) begin
            d = 32'h1357_9bdf ^ b;
            access(1'b0, b[0], d, s);
            check(s[0], w == CRB_W8 || (w == CRB_W32 && b[0]));
            check(s[2:1], {1'b1, w != CRB_W8});
        end
        if (w == CRB_W8)
            want = {4{d[7:0]}};
        else if (w == CRB_W16)
            want = {2{d[15:0]}};
        else
            want = d;
        check(fpcr, want);
        if (w == CRB_W32) begin
            check(fpcr, d);
            access(1'b1, 1'b1, 32'h0, s);
            check(rdata, d);
        end
    endtask

    // later reset must clear state written before it
    task automatic t_soft();
        int n;
        @(posedge i_core_clk);
        i_soft_reset <= 1'b1;
        @(posedge i_core_clk);
        i_soft_reset <= 1'b0;
        low_count(n);
        check(n >= RW && n <= RW + 3, 1'b1);
        repeat (2) @(posedge i_core_clk);
        check_init();
    endtask

    initial begin
        t_width(CRB_W8);
        t_width(CRB_W16);
        t_width(CRB_W32);
        t_soft();
        stop_test();
    end

    initial begin
        repeat (3000) @(posedge i_core_clk);
        err_count++;
        $display("FAIL t=%0t watchdog expired", $time);
        stop_test();
    end
endmodule
